// File: verilog/lcd_host_port_pkg.sv
// shared constants and types for the lcd driver host port
package lcd_host_port_pkg;

  // width of the host data bus and of one transferred byte
  localparam int BUS_W = 8;
  // words held between the host port and the display logic
  localparam int FIFO_DEPTH = 16;
  // serial bits that make one byte
  localparam int SERIAL_BITS = 8;
  localparam int BIT_CNT_W = 3;
  // bit count value at which the byte completes
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RESET = 3'h0;
  // data pins that carry the serial link
  localparam int SERIAL_DATA_BIT = 7;
  localparam int SERIAL_CLOCK_BIT = 6;
  // reset value and output enable levels of the bus side
  localparam logic [BUS_W-1:0] BUS_RESET = 8'h00;
  localparam logic [BUS_W-1:0] OE_ALL = 8'hFF;
  localparam logic [BUS_W-1:0] OE_NONE = 8'h00;
  // strap levels
  localparam logic STYLE_ENABLE_DIR = 1'b1;
  localparam logic IFACE_PARALLEL = 1'b1;
  // select input levels
  localparam logic SEL_DISPLAY = 1'b1;
  localparam logic SEL_COMMAND = 1'b0;

  // one byte from the host with its classification
  typedef struct packed {
    logic isData;
    logic [BUS_W-1:0] value;
  } hostWord_t;

  localparam int WORD_W = $bits(hostWord_t);
  localparam hostWord_t WORD_RESET = '{isData: 1'b0, value: 8'h00};

endpackage

// File: verilog/host_word_fifo.sv
// small synchronous fifo of flip-flops with valid and ready on both sides
`timescale 1ns/1ps
module host_word_fifo
  import lcd_host_port_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] COUNT_MAX = (AW+1)'(DEPTH);

  // whole fifo state in one record
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic full;
    logic empty;
  } fifoState_t;

  fifoState_t st_r;
  fifoState_t st_nxt;
  logic push;
  logic pop;

  // full and empty are kept as flops so the flags never glitch
  assign inReady = !st_r.full;
  assign outValid = !st_r.empty;
  assign outData = st_r.mem[st_r.rdPtr];
  assign push = inValid && !st_r.full;
  assign pop = outReady && !st_r.empty;

  // next state: pointers wrap naturally since depth is a power of two
  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wrPtr] = inData;
      st_nxt.wrPtr = st_r.wrPtr + 1'b1;
    end
    if (pop)
    begin
      st_nxt.rdPtr = st_r.rdPtr + 1'b1;
    end
    if (push && !pop)
    begin
      st_nxt.count = st_r.count + 1'b1;
    end
    else if (pop && !push)
    begin
      st_nxt.count = st_r.count - 1'b1;
    end
    st_nxt.full = (st_nxt.count == COUNT_MAX);
    st_nxt.empty = (st_nxt.count == '0);
  end

  // state register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '{mem: '0, wrPtr: '0, rdPtr: '0, count: '0, full: 1'b0, empty: 1'b1};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // a full fifo must refuse the source
  fifo_full_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_r.count == COUNT_MAX) |-> !inReady && (st_r.wrPtr == st_r.rdPtr))
    else $error("fifo accepts while full");

endmodule

// File: verilog/lcd_driver_host_port.sv
// host side bus port of the lcd driver: parallel and serial byte intake
//
// What this block does
// - eight bit bus, driven only during reads
// - select high means display data, low command
// - transfers taken only while chip select low
// - reset acts on low level of reset
// - strobe style: drive bus while read low
// - strobe style: capture on write strobe rise
// - enable style: read pin is enable clock
// - enable style: write pin high read, low write
// - style strap high enable style, low strobe
// - interface strap high parallel, low serial
// - serial data on bit seven, clock six
// - serial mode is write only
// - serial mode floats and ignores other pins
// - serial shifts msb first, byte at eighth
// - select sampled on every eighth serial edge
// - deselect floats bus, clears serial shifter
// - cycle decode by select and direction
`timescale 1ns/1ps
module lcd_driver_host_port
  import lcd_host_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic serialClk,
  input wire logic [BUS_W-1:0] busIn,
  output logic [BUS_W-1:0] busOut,
  output logic [BUS_W-1:0] busOe,
  input wire logic data_command_select,
  input wire logic chipSelect_n,
  input wire logic readPin,
  input wire logic writePin,
  input wire logic bus_style_select,
  input wire logic parallelSelect,
  input wire logic display_clock_in,
  input wire logic [BUS_W-1:0] displayReadData,
  output logic readDone,
  output logic wordValid,
  input wire logic wordReady,
  output hostWord_t wordOut,
  output logic writeReady,
  output logic overflow,
  input wire logic overflowClear,
  output logic displayClockLevel
);

  // pin synchronisers and the bus side state of the system clock domain
  typedef struct packed {
    logic [BUS_W-1:0] dataS1;
    logic [BUS_W-1:0] dataS2;
    logic csS1;
    logic csS2;
    logic selS1;
    logic selS2;
    logic rdS1;
    logic rdS2;
    logic rdPrev;
    logic wrS1;
    logic wrS2;
    logic wrPrev;
    logic styleS1;
    logic styleS2;
    logic parS1;
    logic parS2;
    logic clkS1;
    logic clkS2;
    logic togS1;
    logic togS2;
    logic togPrev;
    logic driveOn;
    logic [BUS_W-1:0] readByte;
    logic readDone;
    logic pushValid;
    hostWord_t pushWord;
    logic overflow;
    logic writeReady;
  } portState_t;

  // serial shifter, cleared whenever the link is not selected
  typedef struct packed {
    logic [SERIAL_BITS-2:0] shift;
    logic [BIT_CNT_W-1:0] bitCount;
  } shiftState_t;

  // completed serial byte and its event toggle, kept across deselect
  typedef struct packed {
    hostWord_t word;
    logic toggle;
  } holdState_t;

  portState_t st_r;
  portState_t st_nxt;
  shiftState_t sh_r;
  shiftState_t sh_nxt;
  holdState_t hd_r;
  holdState_t hd_nxt;
  logic linkRst_n;
  logic fifoInReady;
  logic csActive;
  logic readActive;
  logic writeEvent;
  logic readEnd;
  logic serialEvent;
  logic wrRise;
  logic rdRise;
  logic enableFall;

  // the serial shifter is held in reset while deselected or in parallel mode;
  // a short chip select glitch may clear a partly shifted byte, which is intended
  assign linkRst_n = reset_n && !chipSelect_n && (parallelSelect != IFACE_PARALLEL);

  // serial shifter on the link clock, msb first from the data bit seven pin
  always_comb
  begin
    sh_nxt = sh_r;
    sh_nxt.shift = {sh_r.shift[SERIAL_BITS-3:0], busIn[SERIAL_DATA_BIT]};
    sh_nxt.bitCount = sh_r.bitCount + 1'b1; // wraps to zero after the eighth edge
  end

  always_ff @(posedge serialClk or negedge linkRst_n)
  begin
    if (!linkRst_n)
    begin
      sh_r <= '{shift: '0, bitCount: BIT_CNT_RESET};
    end
    else
    begin
      sh_r <= sh_nxt;
    end
  end

  // on the eighth edge the byte and the select level are frozen together
  always_comb
  begin
    hd_nxt = hd_r;
    if (sh_r.bitCount == LAST_BIT)
    begin
      hd_nxt.word.value = {sh_r.shift, busIn[SERIAL_DATA_BIT]};
      hd_nxt.word.isData = data_command_select;
      hd_nxt.toggle = !hd_r.toggle;
    end
  end

  // the hold word must not clear on deselect or the crossing would see a false byte
  always_ff @(posedge serialClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hd_r <= '{word: WORD_RESET, toggle: 1'b0};
    end
    else
    begin
      hd_r <= hd_nxt;
    end
  end

  // decode of the synchronised pins
  always_comb
  begin
    csActive = !st_r.csS2 && (st_r.parS2 == IFACE_PARALLEL);
    wrRise = st_r.wrS2 && !st_r.wrPrev;
    rdRise = st_r.rdS2 && !st_r.rdPrev;
    enableFall = !st_r.rdS2 && st_r.rdPrev;
    if (st_r.styleS2 == STYLE_ENABLE_DIR)
    begin
      readActive = csActive && st_r.rdS2 && st_r.wrS2;
      writeEvent = csActive && enableFall && !st_r.wrS2;
      readEnd = csActive && enableFall && st_r.wrS2 && (st_r.selS2 == SEL_DISPLAY);
    end
    else
    begin
      readActive = csActive && !st_r.rdS2;
      writeEvent = csActive && wrRise;
      readEnd = csActive && rdRise && (st_r.selS2 == SEL_DISPLAY);
    end
    // serial bytes are only taken while the interface strap says serial
    serialEvent = (st_r.togS2 != st_r.togPrev) && (st_r.parS2 != IFACE_PARALLEL);
  end

  // next state of the bus side
  always_comb
  begin
    st_nxt = st_r;
    // two flop synchronisers; edge detectors look only at the second stage
    st_nxt.dataS1 = busIn;
    st_nxt.dataS2 = st_r.dataS1;
    st_nxt.csS1 = chipSelect_n;
    st_nxt.csS2 = st_r.csS1;
    st_nxt.selS1 = data_command_select;
    st_nxt.selS2 = st_r.selS1;
    st_nxt.rdS1 = readPin;
    st_nxt.rdS2 = st_r.rdS1;
    st_nxt.rdPrev = st_r.rdS2;
    st_nxt.wrS1 = writePin;
    st_nxt.wrS2 = st_r.wrS1;
    st_nxt.wrPrev = st_r.wrS2;
    st_nxt.styleS1 = bus_style_select;
    st_nxt.styleS2 = st_r.styleS1;
    st_nxt.parS1 = parallelSelect;
    st_nxt.parS2 = st_r.parS1;
    st_nxt.clkS1 = display_clock_in; // level only, the display timing logic is elsewhere
    st_nxt.clkS2 = st_r.clkS1;
    st_nxt.togS1 = hd_r.toggle;
    st_nxt.togS2 = st_r.togS1;
    st_nxt.togPrev = st_r.togS2;
    // drive only during a parallel read; serial mode never drives
    st_nxt.driveOn = readActive;
    if (readActive && !st_r.driveOn)
    begin
      st_nxt.readByte = displayReadData; // byte held for the whole read cycle
    end
    st_nxt.readDone = readEnd;
    // writes of either port go to the fifo as one registered push
    st_nxt.pushValid = 1'b0;
    if (writeEvent)
    begin
      st_nxt.pushValid = 1'b1;
      st_nxt.pushWord = '{isData: (st_r.selS2 == SEL_DISPLAY), value: st_r.dataS2};
    end
    else if (serialEvent)
    begin
      st_nxt.pushValid = 1'b1;
      st_nxt.pushWord = hd_r.word; // stable for eight serial edges, far longer than the sync delay
    end
    // lost word flag; a new loss wins over a clear in the same cycle
    if (st_r.pushValid && !fifoInReady)
    begin
      st_nxt.overflow = 1'b1;
    end
    else if (overflowClear)
    begin
      st_nxt.overflow = 1'b0;
    end
    st_nxt.writeReady = fifoInReady;
  end

  // state register; all bus side state initialises on the low reset level
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '{dataS1: BUS_RESET, dataS2: BUS_RESET, csS1: 1'b1, csS2: 1'b1, selS1: 1'b0, selS2: 1'b0,
                rdS1: 1'b1, rdS2: 1'b1, rdPrev: 1'b1, wrS1: 1'b1, wrS2: 1'b1, wrPrev: 1'b1,
                styleS1: 1'b0, styleS2: 1'b0, parS1: 1'b1, parS2: 1'b1, clkS1: 1'b0, clkS2: 1'b0,
                togS1: 1'b0, togS2: 1'b0, togPrev: 1'b0, driveOn: 1'b0, readByte: BUS_RESET,
                readDone: 1'b0, pushValid: 1'b0, pushWord: WORD_RESET, overflow: 1'b0,
                writeReady: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // word buffer toward the display logic, which may stall it
  host_word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) wordFifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .inValid(st_r.pushValid),
    .inReady(fifoInReady),
    .inData(st_r.pushWord),
    .outValid(wordValid),
    .outReady(wordReady),
    .outData(wordOut)
  );

  // output drivers, all from flops
  assign busOut = st_r.readByte;
  assign busOe = st_r.driveOn ? OE_ALL : OE_NONE;
  assign readDone = st_r.readDone;
  assign overflow = st_r.overflow;
  assign writeReady = st_r.writeReady;
  assign displayClockLevel = st_r.clkS2;

  // steps of a strobe style write: strobe low, then high
  sequence strobeWriteRise_s;
    (st_r.styleS2 != STYLE_ENABLE_DIR) && csActive && !st_r.wrPrev && st_r.wrS2;
  endsequence

  // steps of an enable style write: enable high with direction low, then enable low
  sequence enableWriteFall_s;
    (st_r.styleS2 == STYLE_ENABLE_DIR) && csActive && !st_r.wrS2 && st_r.rdPrev && !st_r.rdS2;
  endsequence

  read_drives_bus_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    readActive |=> (busOe == OE_ALL))
    else $error("bus not driven during read");

  enable_read_drive_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ((st_r.styleS2 == STYLE_ENABLE_DIR) && csActive && st_r.rdS2 && st_r.wrS2) |=> busOe[0])
    else $error("enable style read not driven");

  no_drive_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_r.csS2 || (st_r.parS2 != IFACE_PARALLEL)) |=> (busOe == OE_NONE))
    else $error("bus driven while deselected or serial");

  strobe_write_capture_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    strobeWriteRise_s |=> st_r.pushValid && (st_r.pushWord.value == $past(st_r.dataS2)))
    else $error("strobe write not captured");

  enable_write_capture_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    enableWriteFall_s |=> st_r.pushValid && (st_r.pushWord.value == $past(st_r.dataS2)))
    else $error("enable write not captured");

  word_class_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    writeEvent |=> (st_r.pushWord.isData == $past(st_r.selS2)))
    else $error("write classified wrongly");

  // the byte on the pads is the one display memory offered as the drive began
  read_byte_load_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (readActive && !st_r.driveOn) |=> (busOut == $past(displayReadData)))
    else $error("read byte not loaded at read start");

  // a finished display read gives exactly one done pulse
  read_done_pulse_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    readEnd |=> readDone ##1 !readDone)
    else $error("read done is not a single pulse");

  // a cycle with the select low is never reported as a display read
  command_no_done_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (csActive && (st_r.selS2 == SEL_COMMAND)) |=> !readDone)
    else $error("command cycle reported as display read");

  deselect_ignored_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_r.csS2 && !serialEvent) |=> !st_r.pushValid && !st_r.readDone)
    else $error("activity taken while deselected");

  // the flag holds a second cycle unless a clear came in the first
  overflow_sticky_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_r.pushValid && !fifoInReady) |=> overflow ##1 (overflow || $past(overflowClear)))
    else $error("lost word not flagged");

  serial_byte_edge_a: assert property (@(posedge serialClk) disable iff (!linkRst_n)
    (sh_r.bitCount == LAST_BIT) |=> (hd_r.toggle != $past(hd_r.toggle)) && (sh_r.bitCount == BIT_CNT_RESET))
    else $error("serial byte not completed at eighth edge");

  serial_msb_first_a: assert property (@(posedge serialClk) disable iff (!linkRst_n)
    (sh_r.bitCount == LAST_BIT) |=> (hd_r.word.value[0] == $past(busIn[SERIAL_DATA_BIT]))
      && (hd_r.word.isData == $past(data_command_select)))
    else $error("serial byte or select sampled wrongly");

endmodule

// File: test/host_bus_model.sv
// behavioural host processor that drives the lcd port pins
`timescale 1ns/1ps
module host_bus_model
  import lcd_host_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [BUS_W-1:0] busOut,
  input wire logic [BUS_W-1:0] busOe,
  input wire logic readDone,
  output logic [BUS_W-1:0] busIn,
  output logic serialClk,
  output logic chipSelect_n,
  output logic readPin,
  output logic writePin,
  output logic data_command_select
);
  logic [BUS_W-1:0] hostData; // byte the host puts on the pads
  logic hostOe; // host drives the pads
  logic [BUS_W-1:0] lastWire; // last pad level, for undriven pads
  initial
  begin
    hostData = BUS_RESET;
    hostOe = 1'b0;
    lastWire = BUS_RESET;
    chipSelect_n = 1'b1;
    readPin = 1'b1;
    writePin = 1'b1;
    data_command_select = 1'b0;
  end
  // pad level: device first, then host; a floating pad toggles so no stale value passes
  always_comb
  begin
    for (int i = 0; i < BUS_W; i++)
      busIn[i] = busOe[i] ? busOut[i] : (hostOe ? hostData[i] : ~lastWire[i]);
  end
  always_ff @(posedge sys_clk)
    lastWire <= busIn;
  // the serial clock is the bit six pad itself
  assign serialClk = busIn[SERIAL_CLOCK_BIT];
  // idle levels; in serial mode the host keeps the clock pad low between bytes
  task automatic idle(input logic serial, input logic style);
    chipSelect_n <= 1'b1;
    hostOe <= serial;
    hostData <= BUS_RESET;
    writePin <= 1'b1;
    readPin <= ~style;
  endtask
  // one parallel write; strobes held four cycles so the port sees them
  task automatic parWrite(input logic style, input logic sel, input logic dc, input logic [BUS_W-1:0] v);
    @(posedge sys_clk);
    chipSelect_n <= ~sel;
    data_command_select <= dc;
    hostData <= v;
    hostOe <= 1'b1;
    writePin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    if (style)
      readPin <= 1'b1;
    else
      writePin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    readPin <= ~style;
    repeat (4) @(posedge sys_clk);
    idle(1'b0, style);
  endtask
  // one read; reports what the pads showed and how many done pulses came
  task automatic parRead(input logic style, input logic dc, output logic [BUS_W-1:0] oe,
                         output logic [BUS_W-1:0] dat, output int done);
    @(posedge sys_clk);
    chipSelect_n <= 1'b0;
    data_command_select <= dc;
    // pads stay as idle left them, so in serial mode the clock pad holds low
    writePin <= 1'b1;
    readPin <= style;
    repeat (8) @(posedge sys_clk);
    oe = busOe;
    dat = busIn;
    readPin <= ~style;
    done = 0;
    repeat (6)
    begin
      @(posedge sys_clk);
      if (readDone === 1'b1)
        done++;
    end
    chipSelect_n <= 1'b1;
    @(posedge sys_clk);
  endtask
  // serial byte on its own 48 ns clock, msb first; n below eight leaves a partial byte
  task automatic serByte(input logic dc, input logic [BUS_W-1:0] v, input int n);
    @(posedge sys_clk);
    #3;
    chipSelect_n = 1'b0;
    data_command_select = dc;
    hostOe = 1'b1;
    for (int k = 0; k < n; k++)
    begin
      hostData = {v[BUS_W-1-k], 1'b0, ~hostData[5:0]};
      #24;
      hostData[SERIAL_CLOCK_BIT] = 1'b1;
      #24;
    end
    hostData[SERIAL_CLOCK_BIT] = 1'b0;
    #24;
    @(posedge sys_clk);
    chipSelect_n <= 1'b1;
  endtask
endmodule

// File: test/lcd_driver_host_port_tb.sv
// self-checking bench for the lcd driver host port
`timescale 1ns/1ps
module lcd_driver_host_port_tb;
  import lcd_host_port_pkg::*;
  // mode 0 strobe style, 1 enable style, 2 serial; expected word beside it
  typedef struct packed
  {
    logic [1:0] mode;
    hostWord_t exp;
  } caseRow_t;
  localparam caseRow_t ROWS [6] = '{'{2'h0, 9'h1A5}, '{2'h0, 9'h03C}, '{2'h1, 9'h181},
                                    '{2'h1, 9'h07E}, '{2'h2, 9'h1C3}, '{2'h2, 9'h05A}};
  logic sys_clk, reset_n, serialClk, data_command_select, chipSelect_n, readPin, writePin;
  logic bus_style_select, parallelSelect, display_clock_in, readDone, wordValid, wordReady;
  logic writeReady, overflow, overflowClear, displayClockLevel;
  logic [BUS_W-1:0] busIn, busOut, busOe, displayReadData, oeSeen, datSeen;
  hostWord_t wordOut;
  int fails, check_count, done;
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  lcd_driver_host_port uut (.sys_clk(sys_clk), .reset_n(reset_n), .serialClk(serialClk), .busIn(busIn),
    .busOut(busOut), .busOe(busOe), .data_command_select(data_command_select), .chipSelect_n(chipSelect_n),
    .readPin(readPin), .writePin(writePin), .bus_style_select(bus_style_select), .parallelSelect(parallelSelect),
    .display_clock_in(display_clock_in), .displayReadData(displayReadData), .readDone(readDone),
    .wordValid(wordValid), .wordReady(wordReady), .wordOut(wordOut), .writeReady(writeReady),
    .overflow(overflow), .overflowClear(overflowClear), .displayClockLevel(displayClockLevel));
  host_bus_model host (.sys_clk(sys_clk), .busOut(busOut), .busOe(busOe), .busIn(busIn), .serialClk(serialClk),
    .chipSelect_n(chipSelect_n), .readPin(readPin), .writePin(writePin), .data_command_select(data_command_select),
    .readDone(readDone));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      $display("wrong value at %0t ns: %s", $time, msg);
      fails++;
    end
  endtask
  // straps change only between transfers, then settle through the synchronisers
  task automatic setMode(input logic [1:0] m);
    parallelSelect <= (m != 2'h2);
    bus_style_select <= m[0];
    host.idle(m == 2'h2, m[0]);
    repeat (4) @(posedge sys_clk);
  endtask
  // bounded wait for a word, compare, then pop it
  task automatic popWord(input hostWord_t e);
    int n;
    n = 0;
    while (wordValid !== 1'b1 && n < 60)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (wordValid !== 1'b1)
    begin
      fails++;
      report_and_stop();
    end
    check(wordOut === e, "word at fifo head");
    wordReady <= 1'b1;
    @(posedge sys_clk);
    wordReady <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial
  begin
    reset_n = 1'b0;
    bus_style_select = 1'b0;
    parallelSelect = 1'b1;
    display_clock_in = 1'b0;
    displayReadData = BUS_RESET;
    wordReady = 1'b0;
    overflowClear = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (16) @(posedge sys_clk);
    check(busOe === OE_NONE && wordValid === 1'b0 && overflow === 1'b0 && readDone === 1'b0, "reset");
    reset_n <= 1'b1;
    setMode(2'h0);
    check(writeReady === 1'b1, "ready after reset");
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      setMode(ROWS[i].mode);
      if (ROWS[i].mode == 2'h2)
        host.serByte(ROWS[i].exp.isData, ROWS[i].exp.value, 8);
      else
        host.parWrite(ROWS[i].mode[0], 1'b1, ROWS[i].exp.isData, ROWS[i].exp.value);
      popWord(ROWS[i].exp);
    end
    $display("test write table done");
    // reads in both styles drive the stored byte and end with one done pulse
    for (int s = 0; s < 2; s++)
    begin
      setMode(2'(s));
      displayReadData <= s ? 8'h69 : 8'h96;
      host.parRead(s[0], 1'b1, oeSeen, datSeen, done);
      check(oeSeen === OE_ALL && datSeen === (s ? 8'h69 : 8'h96), "read drive");
      check(done == 1 && busOe === OE_NONE, "read end");
    end
    host.parRead(1'b1, 1'b0, oeSeen, datSeen, done);
    check(done == 0, "command read");
    setMode(2'h2);
    host.parRead(1'b0, 1'b1, oeSeen, datSeen, done);
    check(oeSeen === OE_NONE && done == 0 && wordValid === 1'b0, "serial read");
    $display("test reads done");
    // deselected writes and a partial serial byte leave nothing behind
    setMode(2'h0);
    host.parWrite(1'b0, 1'b0, 1'b1, 8'h11);
    repeat (8) @(posedge sys_clk);
    check(wordValid === 1'b0, "deselected write");
    setMode(2'h2);
    host.serByte(1'b1, 8'hFF, 5);
    host.serByte(1'b0, 8'h96, 8);
    popWord(9'h096);
    $display("test deselect done");
    // fill the fifo while the reader stalls, overflow, clear, drain
    setMode(2'h0);
    for (int i = 0; i < 17; i++)
    begin
      if (i == 16)
        check(writeReady === 1'b0, "fifo full");
      host.parWrite(1'b0, 1'b1, 1'b1, 8'(i));
    end
    check(overflow === 1'b1, "overflow set");
    overflowClear <= 1'b1;
    @(posedge sys_clk);
    overflowClear <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(overflow === 1'b0, "overflow cleared");
    for (int i = 0; i < 16; i++)
      popWord({1'b1, 8'(i)});
    repeat (8) @(posedge sys_clk);
    check(wordValid === 1'b0, "fifo drained");
    $display("test fifo done");
    // display clock is only reflected; the host keeps it low when stopped
    display_clock_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(displayClockLevel === 1'b1, "display clock high");
    display_clock_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check(displayClockLevel === 1'b0, "display clock low");
    // a second reset in mid-run throws away a pending word
    host.parWrite(1'b0, 1'b1, 1'b1, 8'h42);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(wordValid === 1'b0 && busOe === OE_NONE, "mid-run reset");
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(writeReady === 1'b1 && wordValid === 1'b0 && readDone === 1'b0, "after second reset");
    host.parWrite(1'b0, 1'b1, 1'b0, 8'h5C);
    popWord(9'h05C);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
